// file: hw/power_mode_defs.vh
`ifndef POWER_MODE_DEFS_VH
`define POWER_MODE_DEFS_VH

// Register address and width
`define PWR_CTRL_ADDR      8'h87
`define PWR_ADDR_W         8
`define PWR_DATA_W         8

// Field positions of the power control register
`define PWR_BIT_IDLE       0
`define PWR_BIT_HALT       1
`define PWR_BIT_FLAG_LO    2
`define PWR_BIT_FLAG_HI    3
`define PWR_BIT_DOUBLER    7

// Reset value and writable bit mask
`define PWR_CTRL_RESET     8'h00
`define PWR_CTRL_MASK      8'h8F

// Instruction cycle length in clocks and the least external reset hold
`define PWR_INSTR_CLKS     4'hC
`define PWR_RESET_CYCLES   2'h2

// Mode state codes
`define PWR_ST_RUN         2'h0
`define PWR_ST_IDLE        2'h1
`define PWR_ST_HALT        2'h2

`endif

// file: hw/power_mode_control.v
`timescale 1ns/100ps
`include "power_mode_defs.vh"

module power_mode_control (
    // Clock and synchronous reset
    input  wire       clk,
    input  wire       rstn,
    // Register port
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    // Wake and reset sources (pins, synchronised here)
    input  wire       ext_reset,
    input  wire       wdt_reset,
    input  wire       wdt_enabled,
    input  wire       irq_pending,
    input  wire       irq_blocked,
    // Power outputs
    output reg        cpu_clk_en,
    output reg        osc_en,
    output reg        baud_doubler,
    output reg        in_idle,
    output reg        in_halt,
    output reg        core_reset
);

    // Register and mode state
    reg [7:0] power_control_reg;
    reg [1:0] mode;
    reg [3:0] instr_cnt;
    reg [1:0] hold_cnt;

    // Synchroniser stages
    reg ext_meta, ext_sync;
    reg wdt_meta, wdt_sync;
    reg wen_meta, wen_sync;
    reg irq_meta, irq_sync;
    reg blk_meta, blk_sync;

    wire write_hit = wr && (addr == `PWR_CTRL_ADDR);
    wire want_halt = wdata[`PWR_BIT_HALT] && !wen_sync;
    wire want_idle = wdata[`PWR_BIT_IDLE];
    wire wake_irq  = irq_sync && !blk_sync;
    wire hold_done = (hold_cnt == `PWR_RESET_CYCLES);

    // Two-stage synchronisers for asynchronous inputs
    always @(posedge clk) begin
        ext_meta <= ext_reset;
        ext_sync <= ext_meta;
        wdt_meta <= wdt_reset;
        wdt_sync <= wdt_meta;
        wen_meta <= wdt_enabled;
        wen_sync <= wen_meta;
        irq_meta <= irq_pending;
        irq_sync <= irq_meta;
        blk_meta <= irq_blocked;
        blk_sync <= blk_meta;
    end

    // Counts instruction cycles while the external reset is held
    always @(posedge clk) begin
        if (!rstn || !ext_sync) begin
            instr_cnt <= 4'h0;
            hold_cnt  <= 2'h0;
        end else if (!hold_done) begin
            if (instr_cnt == `PWR_INSTR_CLKS - 4'h1) begin
                instr_cnt <= 4'h0;
                hold_cnt  <= hold_cnt + 2'h1;
            end else begin
                instr_cnt <= instr_cnt + 4'h1;
            end
        end
    end

    // Register writes, mode entry and exit
    always @(posedge clk) begin
        if (!rstn) begin
            power_control_reg <= `PWR_CTRL_RESET;
            mode              <= `PWR_ST_RUN;
        end else if ((ext_sync && hold_done) || (wdt_sync && mode != `PWR_ST_HALT)) begin
            power_control_reg <= `PWR_CTRL_RESET;
            mode              <= `PWR_ST_RUN;
        end else begin
            case (mode)
                `PWR_ST_RUN: begin
                    if (write_hit) begin
                        power_control_reg <= wdata & `PWR_CTRL_MASK;
                        if (want_halt)
                            mode <= `PWR_ST_HALT;
                        else if (want_idle)
                            mode <= `PWR_ST_IDLE;
                        if (!want_halt)
                            power_control_reg[`PWR_BIT_HALT] <= 1'b0;
                    end
                end
                `PWR_ST_IDLE: begin
                    if (wake_irq) begin
                        power_control_reg[`PWR_BIT_IDLE] <= 1'b0;
                        mode <= `PWR_ST_RUN;
                    end
                end
                `PWR_ST_HALT: begin
                    mode <= `PWR_ST_HALT;
                end
                default: begin
                    mode <= `PWR_ST_RUN;
                end
            endcase
        end
    end

    // Registered outputs derived from current mode, the register and the reset sources; the clock gates also anticipate a mode-entering write
    always @(posedge clk) begin
        if (!rstn) begin
            cpu_clk_en   <= 1'b1;
            osc_en       <= 1'b1;
            baud_doubler <= 1'b0;
            in_idle      <= 1'b0;
            in_halt      <= 1'b0;
            core_reset   <= 1'b1;
        end else begin
            cpu_clk_en   <= (mode == `PWR_ST_RUN) && !(write_hit && mode == `PWR_ST_RUN
                            && (want_halt || want_idle));
            osc_en       <= !(mode == `PWR_ST_HALT && !ext_sync)
                            && !(write_hit && mode == `PWR_ST_RUN && want_halt);
            baud_doubler <= power_control_reg[`PWR_BIT_DOUBLER];
            in_idle      <= (mode == `PWR_ST_IDLE);
            in_halt      <= (mode == `PWR_ST_HALT);
            core_reset   <= (ext_sync && hold_done) || wdt_sync;
        end
    end

    // Read data one cycle after the strobe
    always @(posedge clk) begin
        if (!rstn)
            rdata <= 8'h00;
        else if (rd && addr == `PWR_CTRL_ADDR)
            rdata <= power_control_reg;
        else
            rdata <= 8'h00;
    end

endmodule // power_mode_control

// file: sim/power_mode_control_properties.sv
`timescale 1ns/100ps
module power_mode_control_properties (
    // Watched ports
    input wire logic       clk, rstn, wr, rd, ext_reset, wdt_reset, wdt_enabled,
    input wire logic       irq_pending, irq_blocked, cpu_clk_en, osc_en,
    input wire logic       baud_doubler, in_idle, in_halt, core_reset,
    input wire logic [7:0] addr, wdata, rdata
);
    logic [5:0] ext_cnt;
    // Run length of the external reset level
    always_ff @(posedge clk) begin
        ext_cnt <= !ext_reset ? 6'h00 : ext_cnt + {5'h00, ext_cnt != 6'h3F};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence wake_req;
        (irq_pending && !irq_blocked)[*6];
    endsequence
    a_unmapped_zero: assert property (rd && addr != 8'h87 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (rd |=> rdata[6:4] == 3'h0)
        else $error("reserved bits set");
    a_idle_gate: assert property (in_idle |-> !cpu_clk_en)
        else $error("cpu clock runs in idle");
    // The oscillator restarts on the external reset, so only a quiet reset pin proves halt
    a_halt_osc: assert property ((!ext_reset)[*4] ##0 in_halt |-> !osc_en)
        else $error("oscillator runs in halt");
    a_halt_prio: assert property (!(in_idle && in_halt))
        else $error("idle and halt together");
    a_wdt_blocks: assert property (wdt_enabled[*4] ##0 (wr && addr == 8'h87 && wdata[1] && !in_halt)
        |=> (!in_halt)[*3])
        else $error("halt entered with watchdog on");
    a_halt_holds: assert property ((!ext_reset)[*3] ##0 in_halt |=> in_halt)
        else $error("halt left without reset");
    a_ext_ends: assert property (ext_cnt == 6'd32 |-> !in_idle && !in_halt && osc_en)
        else $error("external reset ignored");
    a_wake_irq: assert property (in_idle ##0 wake_req |-> !in_idle)
        else $error("idle not left on interrupt");
endmodule // power_mode_control_properties

// file: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, ext_reset = 0, wdt_reset = 0;
    logic wdt_enabled = 0, irq_pending = 0, irq_blocked = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic cpu_clk_en, osc_en, baud_doubler, in_idle, in_halt, core_reset;
    int miscompares = 0, check_count = 0, cyc = 0;
    power_mode_control power_mode_control_i (.*);
    initial forever #10 clk = ~clk;
    // Cycle ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            miscompares++;
            conclude();
        end
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wr_t(input logic [7:0] a, input logic [7:0] d);
        wr <= 1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 0;
        @(posedge clk);
    endtask
    task rd_c(input logic [7:0] a, input logic [7:0] e);
        rd <= 1; addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 check(rdata, e);
        @(posedge clk);
    endtask
    function logic [7:0] reg_exp(input logic [7:0] d);
        return d & 8'h8F;
    endfunction
    task conclude;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h4fcfee6f));
        repeat (4) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        rd_c(8'h87, 8'h00);
        check(baud_doubler, 0);
        repeat (8) begin
            v = $urandom & 8'hFC;
            wr_t(8'h87, v);
            rd_c(8'h87, reg_exp(v));
            check(baud_doubler, v[7]);
            rd_c(8'h90 | $urandom, 8'h00);
        end
        wr_t(8'h87, 8'h0D); // flags marked in the idle-entering write
        @(posedge clk);
        #1 check(cpu_clk_en, 0);
        wr_t(8'h87, 8'h80);
        rd_c(8'h87, 8'h0D);
        irq_blocked <= 1; irq_pending <= 1;
        repeat (10) @(posedge clk);
        check(in_idle, 1);
        irq_blocked <= 0;
        repeat (6) @(posedge clk);
        #1 check(cpu_clk_en, 1);
        irq_pending <= 0;
        rd_c(8'h87, 8'h0C);
        check(core_reset, 0);
        wdt_enabled <= 1;
        repeat (3) @(posedge clk);
        wr_t(8'h87, 8'h03);
        @(posedge clk);
        #1 check({in_halt, in_idle}, 8'h01);
        wdt_reset <= 1;
        repeat (8) @(posedge clk);
        check(core_reset, 1);
        wdt_reset <= 0; wdt_enabled <= 0;
        repeat (4) @(posedge clk);
        #1 check(in_idle, 0);
        wr_t(8'h87, 8'h06);
        @(posedge clk);
        #1 check({in_halt, osc_en}, 8'h02);
        wdt_reset <= 1; irq_pending <= 1;
        repeat (8) @(posedge clk);
        check(in_halt, 1);
        wdt_reset <= 0; irq_pending <= 0; ext_reset <= 1;
        repeat (36) @(posedge clk);
        check(core_reset, 1);
        ext_reset <= 0;
        repeat (4) @(posedge clk);
        #1 check({in_halt, osc_en}, 8'h01);
        rd_c(8'h87, 8'h00);
        conclude();
    end
endmodule // tb_top
bind power_mode_control power_mode_control_properties power_mode_control_properties_i (.*);
